/* rtl/dpsm_pkg.sv */
// constants and types for the drive power state machine
// ****************************************
// Notes on behaviour
// - host steers via command word, reads report
// - self-test runs, fieldbus off, commands ignored
// - self-test done: idle-locked, fieldbus on
// - idle-locked keeps power stage off
// - command from low four bits together
// - idle-locked plus x110 goes armed
// - armed waits for hardware enable if configured
// - armed plus 0111 powers into standby
// - standby plus 1111 goes running
// - armed plus 1111 goes straight to running
// - bit 1 clear drops power stage, except in fault handling
// - any fault ends in fault-halt
// - handling: critical halts, minor runs policy
// - fault-halt switches power stage off
// - leave halt: cause gone plus reset
// - power alive in four named states only
// - running plus x01x starts emergency braking
// - fault reset acts on bit 7 rising
// ****************************************
package dpsm_pkg;
    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [3:0] DPSM_ADDR_CTRL = 4'h0;
    localparam logic [3:0] DPSM_ADDR_REPORT = 4'h4;
    localparam logic [3:0] DPSM_ADDR_CONFIG = 4'h8;
    localparam logic [15:0] DPSM_CTRL_RESET = 16'h0000;
    localparam logic [15:0] DPSM_CONFIG_RESET = 16'h0000;
    // command word fields
    localparam int DPSM_CMD_LSB = 0;
    localparam int DPSM_CMD_W = 4;
    localparam int DPSM_FRESET_BIT = 7;
    // config word fields
    localparam int DPSM_CFG_ENMODE_BIT = 0;
    localparam int DPSM_CFG_BRAKE_LSB = 1;
    localparam int DPSM_CFG_FPOL_LSB = 4;
    localparam int DPSM_CFG_POL_W = 3;
    localparam int DPSM_CFG_OPMODE_LSB = 8;
    localparam int DPSM_CFG_OPMODE_W = 8;
    // report word fields
    localparam int DPSM_REP_POWER_BIT = 8;
    localparam int DPSM_REP_COMM_BIT = 9;
    localparam int DPSM_REP_HWEN_BIT = 10;
    localparam int DPSM_REP_FAULT_BIT = 11;
    // ****************************************
    // timing
    // ****************************************
    localparam int DPSM_CLK_MHZ = 125;
    localparam int DPSM_SELFTEST_US = 100;
    localparam int DPSM_BRAKE_US = 20;
    localparam int DPSM_FREACT_US = 10;
    localparam int DPSM_SELFTEST_CYC = DPSM_SELFTEST_US * DPSM_CLK_MHZ;
    localparam int DPSM_BRAKE_CYC = DPSM_BRAKE_US * DPSM_CLK_MHZ;
    localparam int DPSM_FREACT_CYC = DPSM_FREACT_US * DPSM_CLK_MHZ;
    localparam int DPSM_TIMER_W = 16;
    // ****************************************
    // states, one-hot
    // ****************************************
    typedef enum logic [7:0] {
        DPSM_SELFTEST = 8'h01,
        DPSM_IDLE_LOCKED = 8'h02,
        DPSM_ARMED = 8'h04,
        DPSM_STANDBY = 8'h08,
        DPSM_RUNNING = 8'h10,
        DPSM_EBRAKE = 8'h20,
        DPSM_FHANDLING = 8'h40,
        DPSM_FHALT = 8'h80
    } dpsm_state_t;
endpackage

/* rtl/dpsm_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dpsm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in, // system clock
    input wire logic reset_in, // synchronous reset, high
    input wire logic [WIDTH-1:0] async_in, // pin levels
    output logic [WIDTH-1:0] sync_out // synchronised levels
);
    logic [WIDTH-1:0] meta_r;
    // first flop feeds only the second
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* rtl/dpsm_timer.sv */
// loadable down counter with one-cycle expiry pulse
`timescale 1ns/1ns
module dpsm_timer #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk_in, // system clock
    input wire logic reset_in, // synchronous reset, high
    input wire logic load_in, // restart with value_in
    input wire logic [WIDTH-1:0] value_in, // cycles to run, at least one
    output logic expired_out // pulse when count runs out
);
    logic [WIDTH-1:0] cnt_r;
    // count down, pulse on the last step
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            cnt_r <= '0;
            expired_out <= 1'b0;
        end
        else if (load_in)
        begin
            cnt_r <= value_in;
            expired_out <= 1'b0;
        end
        else
        begin
            expired_out <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
            if (cnt_r != '0)
                cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* rtl/dpsm_top.sv */
// drive power state machine with avalon-mm register slave
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module dpsm_top #(
    parameter int SELFTEST_CYCLES = dpsm_pkg::DPSM_SELFTEST_CYC,
    parameter int BRAKE_CYCLES = dpsm_pkg::DPSM_BRAKE_CYC,
    parameter int FREACT_CYCLES = dpsm_pkg::DPSM_FREACT_CYC
) (
    input wire logic ref_clk_in, // 125 mhz system clock
    input wire logic reset_in, // synchronous reset, high
    input wire logic [3:0] avs_address_in, // byte address
    input wire logic avs_read_in, // read request
    input wire logic avs_write_in, // write request
    input wire logic [31:0] avs_writedata_in, // write data
    input wire logic [3:0] avs_byteenable_in, // byte lanes
    output logic [31:0] avs_readdata_out, // read data
    output logic avs_waitrequest_out, // stall, high by default
    input wire logic hardware_enable_input_in, // enable pin
    input wire logic fault_critical_in, // critical fault pin
    input wire logic fault_minor_in, // non-critical fault pin
    output logic power_stage_on_out, // power stage alive
    output logic comm_active_out, // fieldbus communication active
    output dpsm_pkg::dpsm_state_t state_out, // current state
    output logic [7:0] operating_mode_select_out, // mode to motion logic
    output logic [2:0] brake_policy_out, // braking policy code
    output logic [2:0] fault_policy_out, // fault policy code
    output logic fault_reaction_out // minor-fault reaction running
);
    import dpsm_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    dpsm_state_t state_r;
    dpsm_state_t state_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] config_r;
    logic freset_prev_r;
    logic first_r;
    logic hw_en_s;
    logic fault_crit_s;
    logic fault_minor_s;
    logic timer_load;
    logic [DPSM_TIMER_W-1:0] timer_value;
    logic timer_done;
    logic [3:0] cmd;
    logic freset_edge;
    logic enable_ok;
    logic bus_req;
    logic bus_fire;
    logic [31:0] rd_mux;
    logic [15:0] report;
    logic alive_nxt;

    localparam logic [DPSM_TIMER_W-1:0] SELFTEST_LD = DPSM_TIMER_W'(SELFTEST_CYCLES);
    localparam logic [DPSM_TIMER_W-1:0] BRAKE_LD = DPSM_TIMER_W'(BRAKE_CYCLES);
    localparam logic [DPSM_TIMER_W-1:0] FREACT_LD = DPSM_TIMER_W'(FREACT_CYCLES);

    // ****************************************
    // pin synchronisers
    // ****************************************
    dpsm_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .async_in({hardware_enable_input_in, fault_critical_in, fault_minor_in}),
        .sync_out({hw_en_s, fault_crit_s, fault_minor_s})
    );

    // ****************************************
    // state timer: self-test, braking, fault reaction
    // ****************************************
    dpsm_timer #(
        .WIDTH(DPSM_TIMER_W)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .load_in(timer_load),
        .value_in(timer_value),
        .expired_out(timer_done)
    );

    // reload on reset release and on every state change
    always_comb
    begin
        // a fresh count for every state, so no stale expiry pulse carries over
        timer_load = first_r || (state_nxt != state_r);
        case (state_nxt)
            DPSM_SELFTEST: timer_value = SELFTEST_LD;
            DPSM_EBRAKE: timer_value = BRAKE_LD;
            DPSM_FHANDLING: timer_value = FREACT_LD;
            default: timer_value = BRAKE_LD;
        endcase
    end

    // marks the first cycle after reset so self-test timing starts
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    // ****************************************
    // command decode
    // ****************************************
    // low four bits read as one field
    assign cmd = ctrl_r[DPSM_CMD_LSB +: DPSM_CMD_W];
    // fault reset works on the rising edge only
    assign freset_edge = ctrl_r[DPSM_FRESET_BIT] && !freset_prev_r;
    // hardware enable needed only when configured for inputs plus fieldbus
    assign enable_ok = !config_r[DPSM_CFG_ENMODE_BIT] || hw_en_s;

    // previous bit 7 for edge detection
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            freset_prev_r <= 1'b0;
        else
            freset_prev_r <= ctrl_r[DPSM_FRESET_BIT];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        // commands are levels: the state follows the word while it stands
        state_nxt = state_r;
        case (state_r)
            DPSM_SELFTEST:
            begin
                if (timer_done && !first_r)
                    state_nxt = DPSM_IDLE_LOCKED;
            end
            DPSM_IDLE_LOCKED:
            begin
                if (cmd[2:0] == 3'b110)
                    state_nxt = DPSM_ARMED;
            end
            DPSM_ARMED:
            begin
                if (!cmd[1])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (!cmd[2])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (cmd == 4'hF && enable_ok)
                    state_nxt = DPSM_RUNNING;
                else if (cmd[0] && enable_ok)
                    state_nxt = DPSM_STANDBY;
            end
            DPSM_STANDBY:
            begin
                if (!cmd[1])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (!cmd[2])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (!cmd[0])
                    state_nxt = DPSM_ARMED;
                else if (cmd[3])
                    state_nxt = DPSM_RUNNING;
            end
            DPSM_RUNNING:
            begin
                if (!cmd[1])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (!cmd[2])
                    state_nxt = DPSM_EBRAKE;
                else if (!cmd[0])
                    state_nxt = DPSM_ARMED;
                else if (!cmd[3])
                    state_nxt = DPSM_STANDBY;
            end
            DPSM_EBRAKE:
            begin
                // policy zero ends braking by itself, others hold until disable
                if (!cmd[1])
                    state_nxt = DPSM_IDLE_LOCKED;
                else if (timer_done && config_r[DPSM_CFG_BRAKE_LSB +: DPSM_CFG_POL_W] == 3'h0)
                    state_nxt = DPSM_IDLE_LOCKED;
            end
            DPSM_FHANDLING:
            begin
                // critical ends handling at once, minor after the reaction time
                if (fault_crit_s || timer_done)
                    state_nxt = DPSM_FHALT;
            end
            DPSM_FHALT:
            begin
                if (!fault_crit_s && !fault_minor_s && freset_edge)
                    state_nxt = DPSM_IDLE_LOCKED;
            end
            default: state_nxt = DPSM_FHALT;
        endcase
        // faults win over every command once self-test is over
        if (state_r != DPSM_SELFTEST && state_r != DPSM_FHALT && state_r != DPSM_FHANDLING)
        begin
            if (fault_crit_s)
                state_nxt = DPSM_FHALT;
            else if (fault_minor_s)
                state_nxt = DPSM_FHANDLING;
        end
    end

    // power alive in standby, running, braking and fault handling
    assign alive_nxt = (state_nxt == DPSM_STANDBY) || (state_nxt == DPSM_RUNNING)
        || (state_nxt == DPSM_EBRAKE) || (state_nxt == DPSM_FHANDLING);

    // ****************************************
    // state and power outputs
    // ****************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            state_r <= DPSM_SELFTEST;
            power_stage_on_out <= 1'b0;
            fault_reaction_out <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            // off in idle-locked, armed, self-test and fault-halt
            power_stage_on_out <= alive_nxt;
            fault_reaction_out <= (state_nxt == DPSM_FHANDLING);
        end
    end

    // fieldbus comes up when self-test is over
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            comm_active_out <= 1'b0;
        else
            comm_active_out <= (state_nxt != DPSM_SELFTEST);
    end

    // state leaves straight from its register, so report and pin agree
    assign state_out = state_r;

    // ****************************************
    // avalon-mm slave
    // ****************************************
    // either direction counts; the master never raises both at once
    assign bus_req = avs_read_in || avs_write_in;
    // access completes at the edge where waitrequest is low
    assign bus_fire = bus_req && !avs_waitrequest_out;

    // one wait state, then release for exactly one cycle
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            avs_waitrequest_out <= 1'b1;
        else if (bus_req && avs_waitrequest_out)
            avs_waitrequest_out <= 1'b0;
        else
            avs_waitrequest_out <= 1'b1;
    end

    // state report word
    always_comb
    begin
        report = 16'h0000;
        report[7:0] = state_r;
        report[DPSM_REP_POWER_BIT] = power_stage_on_out;
        report[DPSM_REP_COMM_BIT] = comm_active_out;
        report[DPSM_REP_HWEN_BIT] = hw_en_s;
        report[DPSM_REP_FAULT_BIT] = fault_crit_s || fault_minor_s;
    end

    // read mux, unmapped reads zero
    always_comb
    begin
        case (avs_address_in)
            DPSM_ADDR_CTRL: rd_mux = {16'h0000, ctrl_r};
            DPSM_ADDR_REPORT: rd_mux = {16'h0000, report};
            DPSM_ADDR_CONFIG: rd_mux = {16'h0000, config_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data captured during the wait state
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            avs_readdata_out <= 32'h00000000;
        else if (avs_read_in && avs_waitrequest_out)
            avs_readdata_out <= rd_mux;
    end

    // command word, writes ignored during self-test
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            ctrl_r <= DPSM_CTRL_RESET;
        else if (bus_fire && avs_write_in && avs_address_in == DPSM_ADDR_CTRL
                 && state_r != DPSM_SELFTEST)
        begin
            // only lanes 0 and 1 carry the 16-bit word
            if (avs_byteenable_in[0])
                ctrl_r[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
                ctrl_r[15:8] <= avs_writedata_in[15:8];
        end
    end

    // configuration word, parameter writes open after self-test
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            config_r <= DPSM_CONFIG_RESET;
        else if (bus_fire && avs_write_in && avs_address_in == DPSM_ADDR_CONFIG
                 && state_r != DPSM_SELFTEST)
        begin
            if (avs_byteenable_in[0])
                config_r[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
                config_r[15:8] <= avs_writedata_in[15:8];
        end
    end

    // ****************************************
    // policy outputs to motion logic
    // ****************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            operating_mode_select_out <= 8'h00;
            brake_policy_out <= 3'h0;
            fault_policy_out <= 3'h0;
        end
        else
        begin
            // copies of the config fields, one cycle behind the register
            operating_mode_select_out <= config_r[DPSM_CFG_OPMODE_LSB +: DPSM_CFG_OPMODE_W];
            brake_policy_out <= config_r[DPSM_CFG_BRAKE_LSB +: DPSM_CFG_POL_W];
            fault_policy_out <= config_r[DPSM_CFG_FPOL_LSB +: DPSM_CFG_POL_W];
        end
    end
endmodule

/* sim/dpsm_monitor.sv */
// concurrent checks on the drive power state machine ports
`timescale 1ns/1ns
module dpsm_monitor #(
    parameter int FREACT_CYCLES = 8
) (
    input wire logic ref_clk_in, // system clock
    input wire logic reset_in, // synchronous reset, high
    input wire logic avs_read_in, // bus read
    input wire logic avs_write_in, // bus write
    input wire logic avs_waitrequest_out, // bus stall
    input wire logic fault_critical_in, // critical fault pin
    input wire logic power_stage_on_out, // power stage alive
    input wire logic comm_active_out, // fieldbus active
    input wire dpsm_pkg::dpsm_state_t state_out, // current state
    input wire logic fault_reaction_out // minor-fault reaction
);
    import dpsm_pkg::*;
    // ****************************************
    // state, power and bus relations
    // ****************************************
    localparam int HANDLE_MAX = FREACT_CYCLES + 6;
    logic powered;
    // states in which the power stage must be alive
    assign powered = state_out inside {DPSM_STANDBY, DPSM_RUNNING, DPSM_EBRAKE, DPSM_FHANDLING};
    default clocking mon_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    a_power_by_state: assert property (power_stage_on_out == powered)
        else $error("power stage level does not match state");
    a_comm_after_test: assert property (comm_active_out == (state_out != DPSM_SELFTEST))
        else $error("fieldbus activity does not match self-test");
    a_test_exit_idle: assert property ($past(state_out) == DPSM_SELFTEST && state_out != DPSM_SELFTEST
        |-> state_out == DPSM_IDLE_LOCKED) else $error("self-test left to wrong state");
    a_idle_exit_legal: assert property ($past(state_out) == DPSM_IDLE_LOCKED
        && state_out != DPSM_IDLE_LOCKED |-> state_out inside {DPSM_ARMED, DPSM_FHANDLING, DPSM_FHALT})
        else $error("idle left to wrong state");
    a_run_entry: assert property ($rose(state_out == DPSM_RUNNING)
        |-> $past(state_out) inside {DPSM_ARMED, DPSM_STANDBY}) else $error("running entered from wrong state");
    a_halt_exit_idle: assert property ($past(state_out) == DPSM_FHALT && state_out != DPSM_FHALT
        |-> state_out == DPSM_IDLE_LOCKED) else $error("fault halt left to wrong state");
    a_handling_powered: assert property (state_out == DPSM_FHANDLING
        |-> fault_reaction_out && power_stage_on_out) else $error("fault handling without reaction");
    a_handling_ends: assert property ($rose(state_out == DPSM_FHANDLING)
        |-> ##[1:HANDLE_MAX] state_out == DPSM_FHALT) else $error("fault handling did not end in halt");
    a_critical_halt: assert property (fault_critical_in && state_out != DPSM_SELFTEST
        |-> ##[1:4] state_out == DPSM_FHALT) else $error("critical fault did not halt");
    a_wait_single: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("waitrequest not one cycle low");
    // main scenarios reached
    c_running: cover property (state_out == DPSM_RUNNING);
    c_braking: cover property (state_out == DPSM_EBRAKE);
    c_handling: cover property (state_out == DPSM_FHANDLING);
    c_halt_reset: cover property ($past(state_out) == DPSM_FHALT && state_out == DPSM_IDLE_LOCKED);
endmodule

/* sim/dpsm_host_model.sv */
// fieldbus host model: avalon-mm master issuing commands and polling state
`timescale 1ns/1ns
module dpsm_host_model (
    input wire logic clk_in, // system clock
    input wire logic waitrequest_in, // slave stall
    input wire logic [31:0] readdata_in, // slave read data
    output logic [3:0] address_out, // byte address
    output logic read_out, // read request
    output logic write_out, // write request
    output logic [31:0] writedata_out, // write data
    output logic [3:0] byteenable_out // byte lanes
);
    // ****************************************
    // bus cycles
    // ****************************************
    // idle bus from time zero
    initial
    begin
        address_out = 4'h0;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h00000000;
        byteenable_out = 4'hF;
    end
    // one access held until waitrequest is sampled low; the only way registers are written or state is read
    task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        @(posedge clk_in);
        address_out <= addr;
        writedata_out <= wdata;
        write_out <= wr;
        read_out <= !wr;
        @(posedge clk_in);
        while (waitrequest_in !== 1'b0)
            @(posedge clk_in);
        rdata = readdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
    endtask
    // read the report word until the wanted state shows, bounded
    task automatic poll(input logic [7:0] st, output logic [31:0] rdata);
        access(1'b0, dpsm_pkg::DPSM_ADDR_REPORT, 32'h00000000, rdata);
        for (int i = 0; i < 40 && rdata[7:0] !== st; i++)
            access(1'b0, dpsm_pkg::DPSM_ADDR_REPORT, 32'h00000000, rdata);
    endtask
endmodule

/* sim/drive_power_state_machine_tb_top.sv */
// self-checking bench for the drive power state machine
`timescale 1ns/1ns
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
module drive_power_state_machine_tb_top;
    import dpsm_pkg::*;
    logic ref_clk_in, reset_in, hw_en, fcrit, fminor;
    logic avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] opmode;
    logic [2:0] brake_pol, fault_pol;
    int err_count = 0;
    int checks = 0;
    // 125 mhz clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    dpsm_top #(.SELFTEST_CYCLES(20), .BRAKE_CYCLES(10), .FREACT_CYCLES(8)) DUT (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .hardware_enable_input_in(hw_en),
        .fault_critical_in(fcrit), .fault_minor_in(fminor), .power_stage_on_out(),
        .comm_active_out(), .state_out(), .operating_mode_select_out(opmode),
        .brake_policy_out(brake_pol), .fault_policy_out(fault_pol), .fault_reaction_out()
    );
    dpsm_host_model u_host (
        .clk_in(ref_clk_in), .waitrequest_in(avs_waitrequest), .readdata_in(avs_readdata),
        .address_out(avs_address), .read_out(avs_read), .write_out(avs_write),
        .writedata_out(avs_writedata), .byteenable_out(avs_byteenable)
    );
    // ****************************************
    // helper tasks
    // ****************************************
    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        u_host.access(1'b1, addr, {16'h0000, data}, rd);
    endtask
    // poll for a state, then compare power and state of the report word
    task automatic expect_state(input logic [7:0] st, input logic pow);
        u_host.poll(st, rd);
        `CHK(rd[8:0], {pow, st})
    endtask
    task automatic cmd(input logic [15:0] data, input logic [7:0] st, input logic pow);
        wr(DPSM_ADDR_CTRL, data);
        expect_state(st, pow);
    endtask
    // write a command that must change nothing, then look again later
    task automatic hold(input logic [15:0] data, input logic [7:0] st, input logic pow);
        wr(DPSM_ADDR_CTRL, data);
        repeat (12) @(posedge ref_clk_in);
        u_host.access(1'b0, DPSM_ADDR_REPORT, 32'h00000000, rd);
        `CHK(rd[8:0], {pow, st})
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        print_verdict();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        reset_in = 1'b1;
        hw_en = 1'b0;
        fcrit = 1'b0;
        fminor = 1'b0;
        repeat (12) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        u_host.access(1'b0, DPSM_ADDR_REPORT, 32'h00000000, rd);
        `CHK(rd[9:0], 10'h001)
        wr(DPSM_ADDR_CTRL, 16'h0006); // dropped while testing itself
        u_host.poll(DPSM_IDLE_LOCKED, rd);
        `CHK(rd[9:0], 10'h202)
        wr(DPSM_ADDR_CONFIG, 16'h0300); // parameters set before running
        u_host.access(1'b0, DPSM_ADDR_CONFIG, 32'h00000000, rd);
        `CHK(rd, 32'h00000300)
        `CHK(opmode, 8'h03)
        u_host.access(1'b0, 4'hC, 32'h00000000, rd);
        `CHK(rd, 32'h00000000)
        hold(16'h0007, DPSM_IDLE_LOCKED, 1'b0);
        cmd(16'h0006, DPSM_ARMED, 1'b0);
        cmd(16'h0007, DPSM_STANDBY, 1'b1);
        cmd(16'h000F, DPSM_RUNNING, 1'b1);
        cmd(16'h000B, DPSM_EBRAKE, 1'b1);
        expect_state(DPSM_IDLE_LOCKED, 1'b0);
        cmd(16'h0006, DPSM_ARMED, 1'b0);
        cmd(16'h000F, DPSM_RUNNING, 1'b1);
        cmd(16'h000D, DPSM_IDLE_LOCKED, 1'b0);
        wr(DPSM_ADDR_CONFIG, 16'h0301);
        cmd(16'h0006, DPSM_ARMED, 1'b0);
        hold(16'h000F, DPSM_ARMED, 1'b0);
        hw_en <= 1'b1;
        expect_state(DPSM_RUNNING, 1'b1);
        fminor <= 1'b1;
        expect_state(DPSM_FHALT, 1'b0);
        hold(16'h0080, DPSM_FHALT, 1'b0);
        fminor <= 1'b0;
        hold(16'h0080, DPSM_FHALT, 1'b0);
        wr(DPSM_ADDR_CTRL, 16'h0000);
        cmd(16'h0080, DPSM_IDLE_LOCKED, 1'b0);
        cmd(16'h0006, DPSM_ARMED, 1'b0);
        cmd(16'h0007, DPSM_STANDBY, 1'b1);
        fcrit <= 1'b1;
        expect_state(DPSM_FHALT, 1'b0);
        fcrit <= 1'b0;
        wr(DPSM_ADDR_CTRL, 16'h0000);
        cmd(16'h0080, DPSM_IDLE_LOCKED, 1'b0);
        // braking policy other than zero holds braking until voltage is dropped
        wr(DPSM_ADDR_CONFIG, 16'h0372);
        cmd(16'h0006, DPSM_ARMED, 1'b0);
        `CHK(brake_pol, 3'h1)
        `CHK(fault_pol, 3'h7)
        cmd(16'h000F, DPSM_RUNNING, 1'b1);
        cmd(16'h0007, DPSM_STANDBY, 1'b1);
        cmd(16'h000F, DPSM_RUNNING, 1'b1);
        cmd(16'h000B, DPSM_EBRAKE, 1'b1);
        hold(16'h000B, DPSM_EBRAKE, 1'b1);
        cmd(16'h0009, DPSM_IDLE_LOCKED, 1'b0);
        print_verdict();
    end
endmodule
bind dpsm_top dpsm_monitor #(.FREACT_CYCLES(FREACT_CYCLES)) u_monitor (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out),
    .fault_critical_in(fault_critical_in),
    .power_stage_on_out(power_stage_on_out),
    .comm_active_out(comm_active_out),
    .state_out(state_out),
    .fault_reaction_out(fault_reaction_out)
);
